/* File: byte_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// small flop buffer between fetch and shifter
// ==========================================================
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock, reset and flush
   input  wire logic   sys_clk,
   input  wire logic   reset,
   input  wire logic   flush,
   // streams
   byte_stream_if.sink   inPort,
   byte_stream_if.source outPort
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PW-1:0]    readPtr;
   logic [PW-1:0]    writePtr;
   logic [PW:0]      count;
   logic [PW-1:0]    next_readPtr;
   logic [PW-1:0]    next_writePtr;
   logic [PW:0]      next_count;
   logic             push;
   logic             pop;

   assign inPort.ready  = (count != (PW + 1)'(DEPTH));
   assign outPort.valid = (count != '0);
   assign outPort.data  = store[readPtr];
   assign push          = inPort.valid & inPort.ready;
   assign pop           = outPort.valid & outPort.ready;

   // pointers wrap at depth; flush drops everything buffered
   always_comb begin
      next_readPtr  = readPtr;
      next_writePtr = writePtr;
      next_count    = count;
      if (flush) begin
         next_readPtr  = '0;
         next_writePtr = '0;
         next_count    = '0;
      end else begin
         if (push)
            next_writePtr = (writePtr == PW'(DEPTH - 1)) ? '0 : writePtr + 1'b1;
         if (pop)
            next_readPtr = (readPtr == PW'(DEPTH - 1)) ? '0 : readPtr + 1'b1;
         next_count = count + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         readPtr  <= '0;
         writePtr <= '0;
         count    <= '0;
      end else begin
         readPtr  <= next_readPtr;
         writePtr <= next_writePtr;
         count    <= next_count;
      end
   end

   // storage needs no reset; count guards it
   always_ff @(posedge sys_clk) begin
      if (push && !flush)
         store[writePtr] <= inPort.data;
   end

endmodule : byte_fifo
`default_nettype wire

/* File: byte_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// valid/ready byte stream
// ==========================================================
interface byte_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport source (output data, output valid, input ready);
   modport sink   (input data, input valid, output ready);
endinterface : byte_stream_if
`default_nettype wire

/* File: link_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// host end of the serial link
// ==========================================================
module link_host_model (
   // clock for frame alignment
   input  wire logic sys_clk,
   // link pins
   output logic      linkClk,
   output logic      chipSelect_n,
   output logic      serialIn,
   input  wire logic serialOut,
   input  wire logic serialOutEnable
);
   logic [31:0] rxWord;
   event        wordDone;
   logic        lineSeen;

   // a released data line reads inverted, so a stale bit never passes
   assign lineSeen = serialOutEnable ? serialOut : ~serialOut;

   initial begin
      linkClk      = 1'b0;
      chipSelect_n = 1'b1;
      serialIn     = 1'b0;
   end

   // one frame: tx bits msb first, then rx bits; half is in system clocks
   // link clock stands low outside frames; all pins move on a clock edge
   task automatic frame(input logic [63:0] tx, input int nTx, input int nRx, input int half);
      int i;
      @(posedge sys_clk);
      rxWord = '0;
      chipSelect_n <= 1'b0;
      for (i = 0; i < nTx + nRx; i++) begin
         serialIn <= (i < nTx) ? tx[63-i] : ~serialIn;
         repeat (half) @(posedge sys_clk);
         linkClk <= 1'b1;
         if (i >= nTx) rxWord = {rxWord[30:0], lineSeen};
         repeat (half) @(posedge sys_clk);
         linkClk <= 1'b0;
      end
      repeat (half) @(posedge sys_clk);
      chipSelect_n <= 1'b1;
      // word stays put until the next frame waits for its first edge
      repeat (8) @(posedge sys_clk);
      if (nRx > 0) -> wordDone;
   endtask : frame
endmodule : link_host_model
`default_nettype wire

/* File: seq_table_flash.sv */
`timescale 1ns/100ps
`default_nettype none
module seq_table_flash
   import seq_table_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // serial link pins
   input  wire logic linkClk,
   input  wire logic chipSelect_n,
   input  wire logic serialIn,
   output logic      serialOut,
   output logic      serialOutEnable,
   // mode status
   output logic      quadDoubleRateMode
);

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic sckMeta, sckSync, sckLast;
   logic csMeta, csSync, csLast;
   logic siMeta, siSync;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sckMeta <= 1'b0;
         sckSync <= 1'b0;
         sckLast <= 1'b0;
         csMeta  <= 1'b1;
         csSync  <= 1'b1;
         csLast  <= 1'b1;
         siMeta  <= 1'b0;
         siSync  <= 1'b0;
      end else begin
         sckMeta <= linkClk;
         sckSync <= sckMeta;
         sckLast <= sckSync;
         csMeta  <= chipSelect_n;
         csSync  <= csMeta;
         csLast  <= csSync;
         siMeta  <= serialIn;
         siSync  <= siMeta;
      end
   end

   logic sckRise, sckFall, frameEnd, inFrame;
   assign sckRise  = sckSync & ~sckLast;
   assign sckFall  = ~sckSync & sckLast;
   assign frameEnd = csSync & ~csLast;
   assign inFrame  = ~csSync;

   // ==========================================================
   // parameter space lookup
   // ==========================================================
   // little-endian bytes within each word; past the space reads blank
   function automatic logic [7:0] byteAt(input logic [23:0] addr);
      logic [21:0] word;
      word = addr[23:2];
      if (word < 22'(SPACE_WORDS))
         byteAt = SPACE[word[4:0]][{addr[1:0], 3'b000} +: 8];
      else
         byteAt = BLANK_BYTE;
   endfunction : byteAt

   // ==========================================================
   // output buffer
   // ==========================================================
   byte_stream_if #(.WIDTH(8)) fetchStream ();
   byte_stream_if #(.WIDTH(8)) shiftStream ();

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) outBuffer (
      .sys_clk (sys_clk),
      .reset   (reset),
      .flush   (frameEnd),
      .inPort  (fetchStream.sink),
      .outPort (shiftStream.source)
   );

   // ==========================================================
   // frame decoder
   // ==========================================================
   frame_state_type state, next_state;
   logic [4:0]  bitCount, next_bitCount;
   logic [7:0]  shiftIn, next_shiftIn;
   logic [7:0]  opcode, next_opcode;
   logic [7:0]  modeByte, next_modeByte;
   logic [5:0]  frameBits, next_frameBits;
   logic [23:0] fetchAddr, next_fetchAddr;
   logic        writeEnabled, next_writeEnabled;
   logic        next_quadDoubleRateMode;

   // fetch runs ahead through dummy clocks so the first byte is ready
   assign fetchStream.valid = inFrame & ((state == ST_DUMMY) | (state == ST_DATA));
   assign fetchStream.data  = byteAt(fetchAddr);

   always_comb begin
      next_state              = state;
      next_bitCount           = bitCount;
      next_shiftIn            = shiftIn;
      next_opcode             = opcode;
      next_modeByte           = modeByte;
      next_frameBits          = frameBits;
      next_fetchAddr          = fetchAddr;
      next_writeEnabled       = writeEnabled;
      next_quadDoubleRateMode = quadDoubleRateMode;
      // address simply wraps; no table size is assumed
      if (fetchStream.valid && fetchStream.ready)
         next_fetchAddr = fetchAddr + 24'h000001;
      if (frameEnd) begin
         // a command counts only with exactly its own clock count
         if (opcode == WRITE_EN_CMD && frameBits == WRITE_EN_BITS)
            next_writeEnabled = 1'b1;
         if (opcode == MODE_WRITE_CMD && frameBits == MODE_WRITE_BITS && writeEnabled) begin
            next_quadDoubleRateMode = modeByte[MODE_BIT];
            next_writeEnabled       = 1'b0;
         end
      end
      if (!inFrame) begin
         next_state     = ST_CMD;
         next_bitCount  = '0;
         next_frameBits = '0;
         next_opcode    = '0;
      end else if (sckRise) begin
         if (frameBits != FRAME_BITS_MAX)
            next_frameBits = frameBits + 6'h01;
         next_shiftIn  = {shiftIn[6:0], siSync};
         next_bitCount = bitCount + 5'h01;
         case (state)
            ST_CMD: begin
               if (bitCount == BYTE_LAST_BIT) begin
                  next_opcode   = {shiftIn[6:0], siSync};
                  next_bitCount = '0;
                  if ({shiftIn[6:0], siSync} == READ_PARAM_CMD)
                     next_state = ST_ADDR;
                  else if ({shiftIn[6:0], siSync} == MODE_WRITE_CMD)
                     next_state = ST_MODE;
                  else
                     next_state = ST_SKIP;
               end
            end
            ST_ADDR: begin
               next_fetchAddr = {fetchAddr[22:0], siSync};
               if (bitCount == ADDR_LAST_BIT) begin
                  next_bitCount = '0;
                  next_state    = ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               if (bitCount == DUMMY_LAST_BIT) begin
                  next_bitCount = '0;
                  next_state    = ST_DATA;
               end
            end
            ST_MODE: begin
               if (bitCount == BYTE_LAST_BIT) begin
                  next_modeByte = {shiftIn[6:0], siSync};
                  next_state    = ST_SKIP;
               end
            end
            default: begin
               next_bitCount = bitCount;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state              <= ST_CMD;
         bitCount           <= '0;
         shiftIn            <= '0;
         opcode             <= '0;
         modeByte           <= '0;
         frameBits          <= '0;
         fetchAddr          <= '0;
         writeEnabled       <= 1'b0;
         quadDoubleRateMode <= 1'b0;
      end else begin
         state              <= next_state;
         bitCount           <= next_bitCount;
         shiftIn            <= next_shiftIn;
         opcode             <= next_opcode;
         modeByte           <= next_modeByte;
         frameBits          <= next_frameBits;
         fetchAddr          <= next_fetchAddr;
         writeEnabled       <= next_writeEnabled;
         quadDoubleRateMode <= next_quadDoubleRateMode;
      end
   end

   // ==========================================================
   // data shifter
   // ==========================================================
   logic [7:0] outShift, next_outShift;
   logic [3:0] outBits, next_outBits;
   logic       next_serialOut, next_serialOutEnable;
   logic       loadByte;

   // new byte on the falling edge after the previous one ran out
   assign loadByte          = inFrame & sckFall & (state == ST_DATA) & (outBits == '0);
   assign shiftStream.ready = loadByte;

   always_comb begin
      next_outShift        = outShift;
      next_outBits         = outBits;
      next_serialOut       = serialOut;
      next_serialOutEnable = serialOutEnable;
      if (!inFrame) begin
         next_outBits         = '0;
         next_serialOutEnable = 1'b0;
      end else if (sckFall && state == ST_DATA) begin
         next_serialOutEnable = 1'b1;
         if (outBits == '0) begin
            // an empty buffer here would mean a link far too fast
            next_serialOut = shiftStream.valid ? shiftStream.data[7] : BLANK_BYTE[7];
            next_outShift  = {shiftStream.data[6:0], 1'b0};
            next_outBits   = OUT_BITS_BYTE;
         end else begin
            next_serialOut = outShift[7];
            next_outShift  = {outShift[6:0], 1'b0};
            next_outBits   = outBits - 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         outShift        <= '0;
         outBits         <= '0;
         serialOut       <= 1'b0;
         serialOutEnable <= 1'b0;
      end else begin
         outShift        <= next_outShift;
         outBits         <= next_outBits;
         serialOut       <= next_serialOut;
         serialOutEnable <= next_serialOutEnable;
      end
   end

endmodule : seq_table_flash
`default_nettype wire

/* File: seq_table_flash_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for the flash side
// ==========================================================
module seq_table_flash_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link pins
   input wire logic linkClk,
   input wire logic chipSelect_n,
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic serialOutEnable,
   // status
   input wire logic quadDoubleRateMode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   logic [3:0] idleCount;
   logic [3:0] next_idleCount;

   // cycles since select went high, saturating so it never wraps
   always_comb begin
      next_idleCount = idleCount;
      if (reset || !chipSelect_n) next_idleCount = 4'h0;
      else if (idleCount != 4'hf) next_idleCount = idleCount + 4'h1;
   end
   always_ff @(posedge sys_clk) begin
      idleCount <= next_idleCount;
   end

   property p_reset_quiet;
      $fell(reset) |-> !serialOutEnable && !quadDoubleRateMode && !serialOut;
   endproperty
   property p_drive_in_frame;
      $rose(serialOutEnable) |-> !chipSelect_n && !$past(chipSelect_n);
   endproperty
   property p_release;
      $rose(chipSelect_n) |-> ##[1:6] !serialOutEnable;
   endproperty
   // bit must hold once the link clock has been high for three samples; host samples as the clock rises
   property p_hold_bit;
      serialOutEnable && linkClk && $past(linkClk) && $past(linkClk, 2) |-> $stable(serialOut);
   endproperty
   property p_mode_stays;
      quadDoubleRateMode |=> quadDoubleRateMode;
   endproperty
   property p_mode_at_end;
      $rose(quadDoubleRateMode) |-> chipSelect_n && $past(chipSelect_n);
   endproperty
   property p_idle_release;
      idleCount > 4'h8 |-> !serialOutEnable;
   endproperty
   property p_mode_quiet_read;
      serialOutEnable |-> $stable(quadDoubleRateMode);
   endproperty

   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet after reset");
   a_drive_in_frame: assert property (p_drive_in_frame)
      else $error("data driven outside a frame");
   a_release: assert property (p_release)
      else $error("data line not released after frame");
   a_hold_bit: assert property (p_hold_bit)
      else $error("data bit moved while link clock high");
   a_mode_stays: assert property (p_mode_stays)
      else $error("mode flag dropped");
   a_mode_at_end: assert property (p_mode_at_end)
      else $error("mode changed inside a frame");
   a_idle_release: assert property (p_idle_release)
      else $error("data line driven while idle");
   a_mode_quiet_read: assert property (p_mode_quiet_read)
      else $error("mode changed during a read");

   c_read: cover property ($rose(serialOutEnable));
   c_mode: cover property ($rose(quadDoubleRateMode));
   c_frame: cover property ($rose(chipSelect_n));
endmodule : seq_table_flash_chk

bind seq_table_flash seq_table_flash_chk chk (.sys_clk(sys_clk), .reset(reset),
   .linkClk(linkClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
   .serialOut(serialOut), .serialOutEnable(serialOutEnable),
   .quadDoubleRateMode(quadDoubleRateMode));
`default_nettype wire

/* File: seq_table_flash_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// testbench: host walks the tables, then replays sequences
// ==========================================================
module seq_table_flash_tb
   import seq_table_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        reset;
   logic        linkClk, chipSelect_n, serialIn;
   logic        serialOut, serialOutEnable, quadDoubleRateMode;
   int          fails = 0;
   int          total_checks = 0;
   int          seed, i, n;
   logic [23:0] bp, sp, a;
   logic [7:0]  id;
   // link half period in system clocks: 200 ns link period
   localparam int HALF = 4;
   logic [31:0] got;
   logic [31:0] expQ [$];
   logic [31:0] hdr [0:3] = '{BASIC_HDR0, BASIC_HDR1, SEQ_HDR0, SEQ_HDR1};
   logic [31:0] basic [0:3] = '{BASIC_W0, BASIC_W1, BASIC_W2, BASIC_W3};
   // expected sequence words: length on top, bytes in issue order
   logic [31:0] tbl [0:7] = '{{8'h01, WRITE_EN_CMD, 16'h0}, 32'h0,
      {8'h02, MODE_WRITE_CMD, MODE_VALUE, 8'h00}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   seq_table_flash DUT (.sys_clk(sys_clk), .reset(reset), .linkClk(linkClk),
      .chipSelect_n(chipSelect_n), .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEnable(serialOutEnable), .quadDoubleRateMode(quadDoubleRateMode));
   link_host_model host (.sys_clk(sys_clk), .linkClk(linkClk), .chipSelect_n(chipSelect_n),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutEnable(serialOutEnable));

   always #12.5 sys_clk = ~sys_clk;

   function automatic logic [31:0] sw(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction : sw

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : check

   // read one word; bytes come low byte first
   task automatic rd(input logic [23:0] ad, input logic [31:0] e, output logic [31:0] g);
      expQ.push_back(e);
      host.frame({READ_PARAM_CMD, ad, 32'h0}, 40, 32, HALF);
      g = sw(host.rxWord);
   endtask : rd

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // monitor: each word read is matched against the oldest note
   initial forever begin
      @(host.wordDone);
      check("read word", expQ.pop_front(), sw(host.rxWord));
   end

   // watchdog, well beyond the expected run of about 0.28 ms
   initial begin
      #2ms;
      fails++;
      complete_run;
   end

   initial begin
      reset = 1'b1;
      seed = 32'hb308;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check("reset outputs", 32'h0, {29'h0, serialOut, serialOutEnable, quadDoubleRateMode});
      $display("test reset done");
      // header walk; tables picked by identifier, found through header pointers
      for (i = 0; i < 4; i++) begin
         rd(24'(8 + 4 * i), hdr[i], got);
         if (i % 2 == 0) id = got[7:0];
         else if (id == BASIC_HDR0[7:0]) bp = got[23:0];
         else if (id == SEQ_HDR0[7:0]) sp = got[23:0];
      end
      for (i = 0; i < 4; i++) rd(bp + 24'(4 * i), basic[i], got);
      for (i = 0; i < 8; i++) rd(sp + 24'(4 * i), tbl[i], got);
      rd(sp + 24'h2, {tbl[1][15:0], tbl[0][31:16]}, got);
      // random address past the space, kept clear of the 24-bit wrap
      a = (24'($random(seed)) & 24'h7ffff0) | 24'h000080;
      rd(a, BLANK_WORD, got);
      $display("test table walk done");
      // mode write without enable, and enable with a wrong clock count
      host.frame({MODE_WRITE_CMD, MODE_VALUE, 48'h0}, 16, 0, HALF);
      host.frame({WRITE_EN_CMD, 56'h0}, 9, 0, HALF);
      host.frame({MODE_WRITE_CMD, MODE_VALUE, 48'h0}, 16, 0, HALF);
      check("mode dropped", 32'h0, {31'h0, quadDoubleRateMode});
      // replay in order, only after all reads; zero length ones are skipped
      for (i = 0; i < 4; i++) begin
         n = int'(tbl[2 * i][31:24]);
         if (n != 0)
            host.frame({tbl[2 * i][23:0], tbl[2 * i + 1], 8'h0}, 8 * n, 0, HALF);
         if (i == 0) check("mode early", 32'h0, {31'h0, quadDoubleRateMode});
      end
      check("mode set", 32'h1, {31'h0, quadDoubleRateMode});
      $display("test mode switch done");
      #100;
      complete_run;
   end
endmodule : seq_table_flash_tb
`default_nettype wire

/* File: seq_table_pkg.sv */
`default_nettype none
package seq_table_pkg;

   // ==========================================================
   // link commands and timing
   // ==========================================================
   localparam logic [7:0] READ_PARAM_CMD  = 8'h5a;
   localparam logic [7:0] WRITE_EN_CMD    = 8'h06;
   localparam logic [7:0] MODE_WRITE_CMD  = 8'h72;
   localparam logic [7:0] MODE_VALUE      = 8'h01;
   localparam int         MODE_BIT        = 0;
   localparam logic [5:0] WRITE_EN_BITS   = 6'h08;
   localparam logic [5:0] MODE_WRITE_BITS = 6'h10;
   localparam logic [5:0] FRAME_BITS_MAX  = 6'h3f;
   localparam logic [4:0] ADDR_LAST_BIT   = 5'h17;
   localparam logic [4:0] DUMMY_LAST_BIT  = 5'h07;
   localparam logic [4:0] BYTE_LAST_BIT   = 5'h07;
   localparam logic [3:0] OUT_BITS_BYTE   = 4'h7;

   // ==========================================================
   // parameter space layout
   // ==========================================================
   localparam int          SPACE_WORDS    = 32;
   localparam logic [7:0]  BLANK_BYTE     = 8'hff;
   localparam logic [31:0] BLANK_WORD     = 32'hffffffff;
   // space signature; value is arbitrary
   localparam logic [31:0] SIGNATURE      = 32'h5a3c96e1;
   // access protocol, header count minus one, major, minor
   localparam logic [31:0] SPACE_HEADER   = 32'hff010106;
   // basic table header: nine words at byte 0x20
   localparam logic [31:0] BASIC_HDR0     = 32'h09010000;
   localparam logic [31:0] BASIC_HDR1     = 32'hff000020;
   // sequence table header: eight words at byte 0x44
   localparam logic [31:0] SEQ_HDR0       = 32'h08010009;
   localparam logic [31:0] SEQ_HDR1       = 32'hff000044;
   // basic table words; the first four keep a frozen layout
   localparam logic [31:0] BASIC_W0       = 32'hfff120e5;
   localparam logic [31:0] BASIC_W1       = 32'h00ffffff;
   localparam logic [31:0] BASIC_W2       = 32'h6b08eb44;
   localparam logic [31:0] BASIC_W3       = 32'hbb42ff08;
   // sequence words: length in top byte, then bytes in order
   localparam logic [31:0] SEQ1_W0        = {8'h01, WRITE_EN_CMD, 16'h0000};
   localparam logic [31:0] SEQ2_W0        = {8'h02, MODE_WRITE_CMD, MODE_VALUE, 8'h00};
   localparam logic [31:0] SEQ_UNUSED     = 32'h00000000;

   localparam logic [31:0] SPACE [0:SPACE_WORDS-1] = '{
      0:  SIGNATURE,
      1:  SPACE_HEADER,
      2:  BASIC_HDR0,
      3:  BASIC_HDR1,
      4:  SEQ_HDR0,
      5:  SEQ_HDR1,
      8:  BASIC_W0,
      9:  BASIC_W1,
      10: BASIC_W2,
      11: BASIC_W3,
      17: SEQ1_W0,
      18: SEQ_UNUSED,
      19: SEQ2_W0,
      20: SEQ_UNUSED,
      21: SEQ_UNUSED,
      22: SEQ_UNUSED,
      23: SEQ_UNUSED,
      24: SEQ_UNUSED,
      default: BLANK_WORD
   };

   // ==========================================================
   // frame states
   // ==========================================================
   typedef enum logic [5:0] {
      ST_CMD   = 6'b000001,
      ST_ADDR  = 6'b000010,
      ST_DUMMY = 6'b000100,
      ST_DATA  = 6'b001000,
      ST_MODE  = 6'b010000,
      ST_SKIP  = 6'b100000
   } frame_state_type;

endpackage : seq_table_pkg
`default_nettype wire
